//--- pmbus_regs_pkg.sv
// Constants, field layouts and carrier types of the command register set
package pmbus_regs_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CODE_OUT_CTL  = 8'h01;
    localparam logic [7:0] CODE_OV_ACT   = 8'h41;
    localparam logic [7:0] CODE_OC_ACT   = 8'h47;
    localparam logic [7:0] CODE_OT_ACT   = 8'h50;
    localparam logic [7:0] CODE_IN_FLT   = 8'h7C;
    localparam logic [7:0] CODE_TH_FLT   = 8'h7D;
    localparam logic [7:0] CODE_CM_FLT   = 8'h7E;
    localparam logic [7:0] CODE_VIN      = 8'h88;
    localparam logic [7:0] CODE_VOUT     = 8'h8B;
    localparam logic [7:0] CODE_IOUT     = 8'h8C;
    localparam logic [7:0] CODE_TEMP     = 8'h8D;
    localparam logic [7:0] CODE_REV      = 8'h98;
    localparam logic [7:0] CODE_SERIAL   = 8'h9E;
    localparam logic [7:0] CODE_PIN_FUNC = 8'hE0;
    localparam logic [7:0] CODE_PIN_LOG  = 8'hE1;
    localparam logic [7:0] CODE_PG_POL   = 8'hE2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_OUT_CTL  = 8'h80;
    localparam logic [7:0] RST_OV_ACT   = 8'hB8;
    localparam logic [7:0] RST_OC_ACT   = 8'hF8;
    localparam logic [7:0] RST_OT_ACT   = 8'hB8;
    localparam logic [7:0] RST_PIN_FUNC = 8'h00;
    localparam logic [7:0] RST_PIN_LOG  = 8'h00;
    localparam logic [7:0] RST_PG_POL   = 8'h01;
    // ==========================================================
    // Field positions and encodings
    localparam int CTL_EN_BIT  = 7;
    localparam int CTL_MRG_LO  = 4;
    localparam logic [7:0] CTL_LEGAL = 8'hB0;
    localparam logic [1:0] MRG_BAD   = 2'h3;
    localparam int ACT_RSP_LO  = 6;
    localparam int ACT_RTY_LO  = 3;
    localparam logic [2:0] RTY_NONE  = 3'h0;
    localparam logic [2:0] RTY_LOOP  = 3'h7;
    localparam logic [3:0] PIN_POWER_OK_OUTPUT = 4'h0;
    localparam logic [3:0] PIN_ONOFF = 4'h2;
    localparam int LOG_AND_BIT = 1;
    localparam int IN_OV_BIT   = 7;
    localparam int IN_UV_BIT   = 4;
    localparam int TH_FLT_BIT  = 7;
    localparam int TH_WRN_BIT  = 6;
    localparam int CM_CMD_BIT  = 7;
    localparam int CM_DAT_BIT  = 6;
    localparam int CM_PEC_BIT  = 5;
    // Linear exponents, two's complement in the top five bits
    localparam logic [4:0] EXP_VIN  = 5'h1D;
    localparam logic [4:0] EXP_IOUT = 5'h1C;
    localparam logic [4:0] EXP_TEMP = 5'h1E;
    localparam int VOUT_EXP = -12;
    localparam logic [3:0] SERIAL_LEN = 4'hB;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ    = 200;
    localparam int RESTART_NS = 1000;
    localparam int RESTART_CYC = RESTART_NS * CLK_MHZ / 1000;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] code;
        logic [3:0] idx;
        logic       wr;
        logic [7:0] data;
        logic       pecBad;
    } linkReq_t;
    typedef enum logic [1:0] {
        FLT_RUN  = 2'b01,
        FLT_TRIP = 2'b10
    } fltState_t;
endpackage : pmbus_regs_pkg

//--- pmbus_command_register_set.sv
// Command register set, link crossing and fault response of the module
//
// How it works
// - Control bit 7 enables output; bits 5:4 pick none, low, high margin.
// - Faults shut down per response bits 7:6, defaults B8, F8.
// - Retry field 111 restarts repeatedly while fault persists.
// - Retry field 000 stays shut down until commanded off.
// - Code 88 returns input voltage, linear, exponent -3.
// - Code 8B returns output voltage, linear, exponent -12.
// - Code 8C returns output current, linear, exponent -4.
// - Code 8D returns hot-spot temperature, linear, exponent -2.
// - Code 7C reports input over and undervoltage flags.
// - Code 7D reports temperature fault and warning flags.
// - Code 7E reports communication fault flags.
// - Code 98 returns a fixed protocol revision code.
// - Code 9E block read returns serial as 11 characters.
// - Codes E0, E1 pick aux pin function and logic, reset 00.
// - Code E2 sets power-good polarity, reset 01 positive.
// - Pin function 0000 gives power-good out, 0010 on/off in.
// - Logic bit 1 set requires primary and secondary on/off.
// - Comm byte bits 7, 6, 5: bad command, data, packet check.
// - Input byte bit 7 overvoltage, bit 4 undervoltage.
`timescale 1ns/1ps
module pmbus_command_register_set
    import pmbus_regs_pkg::*;
#(
    parameter logic [7:0]  REV_CODE    = 8'h11, // Arbitrary value
    parameter logic [87:0] SERIAL_TEXT = "00000000000",
    parameter int          RESTART_GAP = RESTART_CYC
) (
    // System clock and reset
    input  logic        sys_clk,
    input  logic        rstn,
    // Link side, framing done outside, on its own clock
    input  logic        linkClk,
    input  logic        cmdValid,
    input  linkReq_t    cmdReq,
    output logic        cmdReady,
    output logic        rspValid,
    output logic [7:0]  rspByte,
    // Telemetry from the converter logic
    input  logic [10:0] vinMant,
    input  logic [15:0] voutMant,
    input  logic [10:0] ioutMant,
    input  logic [10:0] tempMant,
    // Fault and warning detectors
    input  logic [2:0]  faultIn,
    input  logic        otWarn,
    input  logic        vinOv,
    input  logic        vinUv,
    input  logic        voutGood,
    // Pins
    input  logic        onOffPin,
    input  logic        auxPinIn,
    output logic        auxPinOut,
    output logic        auxPinOeN,
    // Power stage control
    output logic        outputOn,
    output logic [1:0]  marginSel
);
    // ==========================================================
    // Link domain
    logic       lRst0, lRst1;
    logic       reqTogQ, ackS0, ackS1, ackS2, readyQ;
    logic       rspValidQ;
    logic [7:0] rspByteQ;
    linkReq_t   reqHoldQ;
    logic       ackTogQ;
    logic [7:0] ansQ;
    wire logic  ackEvt  = ackS1 ^ ackS2;
    wire logic  takeReq = cmdValid && readyQ;

    // Reset brought into the link domain as a level
    always_ff @(posedge linkClk) begin
        lRst0 <= rstn;
        lRst1 <= lRst0;
    end

    // Request held stable until the system side answers
    always_ff @(posedge linkClk) begin
        if (!lRst1) begin
            reqTogQ   <= 1'b0;
            readyQ    <= 1'b1;
            rspValidQ <= 1'b0;
            rspByteQ  <= 8'h00;
            reqHoldQ  <= '0;
            ackS0     <= 1'b0;
            ackS1     <= 1'b0;
            ackS2     <= 1'b0;
        end else begin
            ackS0     <= ackTogQ;
            ackS1     <= ackS0;
            ackS2     <= ackS1;
            rspValidQ <= ackEvt;
            if (takeReq) begin
                reqHoldQ <= cmdReq;
                reqTogQ  <= ~reqTogQ;
                readyQ   <= 1'b0;
            end else if (ackEvt) begin
                readyQ <= 1'b1;
            end
            if (ackEvt) begin
                rspByteQ <= ansQ; // Stable: set in the same cycle as the toggle
            end
        end
    end

    assign cmdReady = readyQ;
    assign rspValid = rspValidQ;
    assign rspByte  = rspByteQ;

    // ==========================================================
    // Crossing into the system domain
    logic reqS0, reqS1, reqS2;
    logic onS0, onS1, auxS0, auxS1;
    wire logic reqEvt = reqS1 ^ reqS2;

    // Toggle and pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reqS0 <= 1'b0;
            reqS1 <= 1'b0;
            reqS2 <= 1'b0;
            onS0  <= 1'b0;
            onS1  <= 1'b0;
            auxS0 <= 1'b0;
            auxS1 <= 1'b0;
        end else begin
            reqS0 <= reqTogQ;
            reqS1 <= reqS0;
            reqS2 <= reqS1;
            onS0  <= onOffPin;
            onS1  <= onS0;
            auxS0 <= auxPinIn;
            auxS1 <= auxS0;
        end
    end

    // ==========================================================
    // Command decode
    wire logic [7:0] code = reqHoldQ.code;
    wire logic [3:0] idx  = reqHoldQ.idx;
    wire logic [7:0] wDat = reqHoldQ.data;
    wire logic isCtl   = code == CODE_OUT_CTL;
    wire logic isInF   = code == CODE_IN_FLT;
    wire logic isThF   = code == CODE_TH_FLT;
    wire logic isCmF   = code == CODE_CM_FLT;
    wire logic isFunc  = code == CODE_PIN_FUNC;
    wire logic isLog   = code == CODE_PIN_LOG;
    wire logic isPol   = code == CODE_PG_POL;
    wire logic isWrite = isCtl || isInF || isThF || isCmF
                      || isFunc || isLog || isPol;
    wire logic isRead  = isWrite || code == CODE_OV_ACT
                      || code == CODE_OC_ACT || code == CODE_OT_ACT
                      || code == CODE_VIN || code == CODE_VOUT
                      || code == CODE_IOUT || code == CODE_TEMP
                      || code == CODE_REV || code == CODE_SERIAL;
    wire logic wrEvt   = reqEvt && reqHoldQ.wr && !reqHoldQ.pecBad;
    wire logic badCmd  = reqEvt && !(reqHoldQ.wr ? isWrite : isRead);
    // Reserved bits or the undefined margin code are refused
    wire logic badCtl  = (wDat & ~CTL_LEGAL) != 8'h00
                      || wDat[CTL_MRG_LO +: 2] == MRG_BAD;
    wire logic badDat  = wrEvt && isCtl && badCtl;
    wire logic wrCtl   = wrEvt && isCtl && !badCtl;

    // ==========================================================
    // Writable registers
    logic [7:0] ctlQ, funcQ, logQ, polQ;
    logic [7:0] inFltQ, thFltQ, cmFltQ;

    // Control and pin configuration bytes
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctlQ  <= RST_OUT_CTL;
            funcQ <= RST_PIN_FUNC;
            logQ  <= RST_PIN_LOG;
            polQ  <= RST_PG_POL;
        end else begin
            if (wrCtl)
                ctlQ <= wDat;
            if (wrEvt && isFunc)
                funcQ <= wDat;
            if (wrEvt && isLog)
                logQ <= wDat;
            if (wrEvt && isPol)
                polQ <= wDat;
        end
    end

    // Sticky flags: write one to clear, a new event wins
    wire logic [7:0] inSet = ({7'h00, vinOv} << IN_OV_BIT)
                           | ({7'h00, vinUv} << IN_UV_BIT);
    wire logic [7:0] thSet = ({7'h00, faultIn[2]} << TH_FLT_BIT)
                           | ({7'h00, otWarn} << TH_WRN_BIT);
    wire logic [7:0] cmSet =
        ({7'h00, badCmd} << CM_CMD_BIT)
      | ({7'h00, badDat} << CM_DAT_BIT)
      | ({7'h00, reqEvt && reqHoldQ.pecBad} << CM_PEC_BIT);
    wire logic [7:0] inClr = (wrEvt && isInF) ? wDat : 8'h00;
    wire logic [7:0] thClr = (wrEvt && isThF) ? wDat : 8'h00;
    wire logic [7:0] cmClr = (wrEvt && isCmF) ? wDat : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            inFltQ <= 8'h00;
            thFltQ <= 8'h00;
            cmFltQ <= 8'h00;
        end else begin
            inFltQ <= (inFltQ & ~inClr) | inSet;
            thFltQ <= (thFltQ & ~thClr) | thSet;
            cmFltQ <= (cmFltQ & ~cmClr) | cmSet;
        end
    end

    // ==========================================================
    // Fault response: fixed bytes, one small machine per class
    wire logic [7:0] act [3] = '{RST_OV_ACT, RST_OC_ACT, RST_OT_ACT};
    logic [2:0] shutQ;
    logic [7:0] gapQ [3];
    fltState_t  fsmQ [3];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flt
            wire logic [1:0] rsp = act[gi][ACT_RSP_LO +: 2];
            wire logic [2:0] rty = act[gi][ACT_RTY_LO +: 3];
            wire logic gapEnd =
                gapQ[gi] == 8'(RESTART_GAP - 1);
            // Delay field ignored: trip in the first cycle the fault is high
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    fsmQ[gi]  <= FLT_RUN;
                    shutQ[gi] <= 1'b0;
                    gapQ[gi]  <= 8'h00;
                end else begin
                    case (fsmQ[gi])
                        FLT_RUN: begin
                            gapQ[gi] <= 8'h00;
                            if (faultIn[gi] && rsp != 2'h0) begin
                                fsmQ[gi]  <= FLT_TRIP;
                                shutQ[gi] <= 1'b1;
                            end
                        end
                        FLT_TRIP: begin
                            gapQ[gi] <= gapQ[gi] + 8'h01;
                            if ((rty == RTY_LOOP && gapEnd)
                                || !ctlQ[CTL_EN_BIT]) begin // Commanded off
                                fsmQ[gi]  <= FLT_RUN;
                                shutQ[gi] <= 1'b0;
                            end
                        end
                        default: begin
                            fsmQ[gi]  <= FLT_RUN;
                            shutQ[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ==========================================================
    // Output enable, margin and auxiliary pin
    logic       outOnQ, auxOutQ, auxOeNQ;
    logic [1:0] marginQ;
    wire logic auxIsOnOff = funcQ[3:0] == PIN_ONOFF;
    wire logic secOk = !(auxIsOnOff && logQ[LOG_AND_BIT]) || auxS1;
    wire logic runReq = ctlQ[CTL_EN_BIT] && onS1 && secOk
                     && shutQ == 3'h0;
    wire logic power_ok_output  = outOnQ && voutGood;

    // Power-good drives the pin only in its output role
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            outOnQ  <= 1'b0;
            marginQ <= 2'h0;
            auxOutQ <= 1'b0;
            auxOeNQ <= 1'b1;
        end else begin
            outOnQ  <= runReq;
            marginQ <= ctlQ[CTL_MRG_LO +: 2];
            auxOutQ <= polQ[0] ? power_ok_output : !power_ok_output;
            auxOeNQ <= funcQ[3:0] != PIN_POWER_OK_OUTPUT;
        end
    end

    assign outputOn  = outOnQ;
    assign marginSel = marginQ;
    assign auxPinOut = auxOutQ;
    assign auxPinOeN = auxOeNQ;

    // ==========================================================
    // Read answer: words give low byte at index 0
    wire logic [15:0] vinWord  = {EXP_VIN, vinMant};
    wire logic [15:0] voutWord = voutMant;
    wire logic [15:0] ioutWord = {EXP_IOUT, ioutMant};
    wire logic [15:0] tempWord = {EXP_TEMP, tempMant};
    wire logic [15:0] wordSel =
        code == CODE_VIN  ? vinWord  :
        code == CODE_VOUT ? voutWord :
        code == CODE_IOUT ? ioutWord : tempWord;
    wire logic [6:0] serOfs = 7'(88 - 8 * idx);
    wire logic [7:0] serByte =
        idx == 4'h0 ? {4'h0, SERIAL_LEN} :
        idx > SERIAL_LEN ? 8'h00 :
        SERIAL_TEXT[serOfs +: 8];
    wire logic [7:0] rdByte =
        isCtl  ? ctlQ   : isFunc ? funcQ  : isLog ? logQ :
        isPol  ? polQ   : isInF  ? inFltQ : isThF ? thFltQ :
        isCmF  ? cmFltQ :
        code == CODE_OV_ACT ? RST_OV_ACT :
        code == CODE_OC_ACT ? RST_OC_ACT :
        code == CODE_OT_ACT ? RST_OT_ACT :
        code == CODE_REV    ? REV_CODE   :
        code == CODE_SERIAL ? serByte    :
        !isRead ? 8'h00 :
        idx[0]  ? wordSel[15:8] : wordSel[7:0];

    // Answer latched in the same cycle as the acknowledge toggle leaves
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ansQ    <= 8'h00;
            ackTogQ <= 1'b0;
        end else if (reqEvt) begin
            ansQ    <= rdByte;
            ackTogQ <= ~ackTogQ;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_EN_OFF: assert property (
        !ctlQ[CTL_EN_BIT] |=> !outOnQ)
        else $error("output on while disabled");
    AST_MARGIN: assert property (
        wrCtl |=> ##1 marginQ == $past(wDat[CTL_MRG_LO +: 2], 2))
        else $error("margin not applied");
    AST_TRIP: assert property (
        fsmQ[1] == FLT_RUN && faultIn[1] |=> shutQ[1] ##1 !outOnQ)
        else $error("current fault did not shut down");
    AST_LOOP: assert property (
        shutQ[0] && gapQ[0] == 8'(RESTART_GAP - 1) |=> !shutQ[0])
        else $error("no restart after gap");
    AST_HOLD: assert property (
        shutQ[2] && ctlQ[CTL_EN_BIT] && gapQ[2] == 8'h05
        |=> shutQ[2] && !outOnQ)
        else $error("latched fault released");
    AST_VIN: assert property (
        reqEvt && code == CODE_VIN && idx == 4'h1
        |=> ansQ == {EXP_VIN, $past(vinMant[10:8])})
        else $error("input voltage word wrong");
    AST_REV: assert property (
        reqEvt && code == CODE_REV && !reqHoldQ.wr |=> ansQ == REV_CODE)
        else $error("revision code wrong");
    AST_SERLEN: assert property (
        reqEvt && code == CODE_SERIAL && idx == 4'h0 |=> ansQ == 8'h0B)
        else $error("serial length not 11");
    AST_BADCMD: assert property (
        reqEvt && !isRead |=> cmFltQ[CM_CMD_BIT])
        else $error("invalid command not flagged");
    AST_UV: assert property (
        vinUv |=> inFltQ[IN_UV_BIT] && !inFltQ[3])
        else $error("undervoltage flag wrong");
    AST_PGPIN: assert property (
        funcQ[3:0] == PIN_ONOFF |=> auxOeNQ)
        else $error("pin driven in input role");

    COV_RETRY: cover property (shutQ[0] ##1 !shutQ[0]);
    COV_SERIAL: cover property (reqEvt && code == CODE_SERIAL);
    COV_CLEAR: cover property (wrEvt && isCmF && cmFltQ != 8'h00);
    COV_AND: cover property (auxIsOnOff && logQ[LOG_AND_BIT] && outOnQ);
endmodule : pmbus_command_register_set

//--- link_host_model.sv
// Host side model that issues link requests and collects the answers
`timescale 1ns/1ps
module link_host_model
    import pmbus_regs_pkg::*;
(
    // Link clock
    input  logic       linkClk,
    // Request side
    output linkReq_t   cmdReq,
    output logic       cmdValid,
    input  logic       cmdReady,
    // Answer side
    input  logic       rspValid,
    input  logic [7:0] rspByte
);
    int gap = 0; // Idle link cycles before a request, for slow hosts

    // Idle lines at start, nothing requested
    initial begin
        cmdValid = 1'b0;
        cmdReq   = '0;
    end

    // ==========================================================
    // One request, held until taken, then wait for its answer
    task automatic xfer(input linkReq_t req, output logic [7:0] rsp,
                        output bit ok);
        int n;
        bit took;
        ok   = 1'b0;
        took = 1'b0;
        rsp  = 8'h00;
        repeat (gap + 1) @(posedge linkClk);
        cmdValid <= 1'b1;
        cmdReq   <= req;
        for (n = 0; n < 20 && !took; n++) begin
            @(negedge linkClk);
            took = cmdReady;
        end
        if (took) @(posedge linkClk);
        cmdValid <= 1'b0;
        cmdReq   <= ~req; // Released lines must not keep the old value
        for (n = 0; n < 40 && took && !ok; n++) begin
            @(negedge linkClk);
            if (rspValid) begin
                ok  = 1'b1;
                rsp = rspByte;
            end
        end
    endtask : xfer
endmodule : link_host_model

//--- tb_top.sv
// Self-checking bench for the command register set
`timescale 1ns/1ps
module tb_top
    import pmbus_regs_pkg::*;
();
    // ==========================================================
    // Signals
    localparam logic [87:0] SER = "K7Q2M9X4T1W"; // Arbitrary text
    localparam logic [7:0]  REV = 8'h5A;         // Arbitrary value
    logic        sys_clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        rstn, cmdValid, cmdReady, rspValid;
    linkReq_t    cmdReq;
    logic [7:0]  rspByte, rb;
    logic [10:0] vinMant, ioutMant, tempMant;
    logic [15:0] voutMant;
    logic [2:0]  faultIn;
    logic        otWarn, vinOv, vinUv, voutGood, onOffPin, extLevel;
    logic        auxPinIn, auxPinOut, auxPinOeN, outputOn;
    logic [1:0]  marginSel;
    logic [7:0]  tCode[4], rCode[7], rVal[7];
    logic [15:0] tExp[4];
    int          failCount = 0;
    int          totalChecks = 0;
    bit          ok;

    // Clocks of unrelated periods
    always #2.5 sys_clk = ~sys_clk;
    always #3.0 linkClk = ~linkClk;

    // Aux pin wire: device level when it drives, else the outside level
    assign auxPinIn = auxPinOeN ? extLevel : auxPinOut;

    // ==========================================================
    // Instances
    pmbus_command_register_set #(.REV_CODE(REV), .SERIAL_TEXT(SER),
        .RESTART_GAP(8)) u_pmbus_command_register_set (
        .sys_clk(sys_clk), .rstn(rstn), .linkClk(linkClk),
        .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspByte(rspByte), .vinMant(vinMant),
        .voutMant(voutMant), .ioutMant(ioutMant), .tempMant(tempMant),
        .faultIn(faultIn), .otWarn(otWarn), .vinOv(vinOv),
        .vinUv(vinUv), .voutGood(voutGood), .onOffPin(onOffPin),
        .auxPinIn(auxPinIn), .auxPinOut(auxPinOut),
        .auxPinOeN(auxPinOeN), .outputOn(outputOn),
        .marginSel(marginSel));
    link_host_model u_link_host_model (.linkClk(linkClk),
        .cmdReq(cmdReq), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspByte(rspByte));

    // ==========================================================
    // Tasks
    task automatic final_report();
        $display("Checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // A lost answer would stall everything after it, so stop the run
    task automatic io(input logic [7:0] code, input logic [3:0] idx,
                      input logic wr, input logic [7:0] data,
                      input logic pec);
        u_link_host_model.xfer(linkReq_t'{code, idx, wr, data, pec}, rb,
                               ok);
        if (!ok) begin
            failCount++;
            $display("[FAIL] %0t link request timed out", $time);
            final_report();
        end
    endtask : io

    task automatic rdChk(input logic [7:0] code, input logic [3:0] idx,
                         input logic [7:0] exp);
        io(code, idx, 1'b0, 8'h00, 1'b0);
        chk({8'h00, rb}, {8'h00, exp}, $sformatf("read of %h", code));
    endtask : rdChk

    task automatic wrt(input logic [7:0] code, input logic [7:0] data);
        io(code, 4'h0, 1'b1, data, 1'b0);
        repeat (3) @(negedge sys_clk);
    endtask : wrt

    task automatic rdWord(input logic [7:0] code, input logic [15:0] exp);
        logic [7:0] lo;
        io(code, 4'h0, 1'b0, 8'h00, 1'b0);
        lo = rb;
        io(code, 4'h1, 1'b0, 8'h00, 1'b0);
        chk({rb, lo}, exp, "telemetry word");
    endtask : rdWord

    task automatic waitOn(input logic exp, input int lim);
        int n;
        for (n = 0; n < lim && outputOn !== exp; n++) @(negedge sys_clk);
        chk({15'h0, outputOn}, {15'h0, exp}, "output run state");
        // A used-up wait bound ends the run
        if (outputOn !== exp) final_report();
    endtask : waitOn

    function automatic logic [15:0] lin(input int e, input logic [10:0] m);
        return {e[4:0], m};
    endfunction : lin

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        {vinMant, ioutMant, tempMant, voutMant} = '0;
        {faultIn, otWarn, vinOv, vinUv} = '0;
        {voutGood, onOffPin, extLevel} = 3'b111;
        rCode = '{8'h01, 8'h41, 8'h47, 8'h50, 8'hE0, 8'hE1, 8'hE2};
        rVal  = '{8'h80, 8'hB8, 8'hF8, 8'hB8, 8'h00, 8'h00, 8'h01};
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (10) @(posedge sys_clk);
        for (int i = 0; i < 4; i++)
            rdChk(rCode[i], 4'h0, rVal[i]);
        for (int i = 4; i < 7; i++)
            rdChk(rCode[i], 4'h0, rVal[i]);
        waitOn(1'b1, 10);
        for (int m = 1; m < 3; m++) begin
            wrt(8'h01, {2'b10, m[1:0], 4'h0});
            chk({14'h0, marginSel}, m[15:0], "margin");
        end
        wrt(8'h01, 8'hB0); // Margin 11 is refused
        rdChk(8'h01, 4'h0, 8'hA0);
        wrt(8'h01, 8'h00);
        waitOn(1'b0, 10);
        wrt(8'h01, 8'h80);
        waitOn(1'b1, 10);
        // Telemetry, a negative mantissa among them
        @(posedge sys_clk);
        vinMant  <= 11'h7F3;
        voutMant <= 16'hC000;
        ioutMant <= 11'h155;
        tempMant <= 11'h064;
        @(posedge sys_clk);
        tCode = '{8'h88, 8'h8B, 8'h8C, 8'h8D};
        tExp  = '{lin(-3, vinMant), voutMant, lin(-4, ioutMant),
                  lin(-2, tempMant)};
        for (int i = 0; i < 2; i++)
            rdWord(tCode[i], tExp[i]);
        for (int i = 2; i < 4; i++)
            rdWord(tCode[i], tExp[i]);
        // Identity reads through a slow host
        u_link_host_model.gap = 4;
        rdChk(8'h98, 4'h0, REV);
        rdChk(8'h9E, 4'h0, 8'h0B);
        for (int i = 1; i < 12; i++)
            rdChk(8'h9E, i[3:0], SER[8*(11-i) +: 8]);
        rdChk(8'h9E, 4'hC, 8'h00); // Past the last character
        u_link_host_model.gap = 0;
        // Sticky input flags, cleared by writing ones
        @(posedge sys_clk) vinOv <= 1'b1;
        @(posedge sys_clk) vinOv <= 1'b0;
        rdChk(8'h7C, 4'h0, 8'h80);
        @(posedge sys_clk) vinUv <= 1'b1;
        @(posedge sys_clk) vinUv <= 1'b0;
        rdChk(8'h7C, 4'h0, 8'h90);
        wrt(8'h7C, 8'h90);
        rdChk(8'h7C, 4'h0, 8'h00);
        @(posedge sys_clk) otWarn <= 1'b1;
        @(posedge sys_clk) otWarn <= 1'b0;
        rdChk(8'h7D, 4'h0, 8'h40);
        wrt(8'h7D, 8'h40);
        // Refused requests: unknown code, read-only write, bad check
        rdChk(8'h00, 4'h0, 8'h00);
        wrt(8'h41, 8'h00);
        rdChk(8'h41, 4'h0, 8'hB8);
        io(8'hE2, 4'h0, 1'b1, 8'h00, 1'b1);
        rdChk(8'hE2, 4'h0, 8'h01);
        rdChk(8'h7E, 4'h0, 8'hE0);
        wrt(8'h7E, 8'hE0);
        rdChk(8'h7E, 4'h0, 8'h00);
        // Each fault class shuts down at once and restarts when gone
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk) faultIn[i] <= 1'b1;
            waitOn(1'b0, 4);
            repeat (30) @(posedge sys_clk);
            faultIn[i] <= 1'b0;
            waitOn(1'b1, 20);
        end
        rdChk(8'h7D, 4'h0, 8'h80);
        // Aux pin as power-good output, then as second on/off input
        chk({14'h0, auxPinOeN, auxPinOut}, 16'h1,
            "power good pin");
        wrt(8'hE2, 8'h00);
        chk({15'h0, auxPinOut}, 16'h0, "inverted power good");
        wrt(8'hE0, 8'h02);
        chk({15'h0, auxPinOeN}, 16'h1, "aux pin released");
        @(posedge sys_clk) extLevel <= 1'b0;
        repeat (6) @(posedge sys_clk);
        waitOn(1'b1, 2);
        wrt(8'hE1, 8'h02);
        waitOn(1'b0, 10);
        @(posedge sys_clk) extLevel <= 1'b1;
        waitOn(1'b1, 10);
        final_report();
    end
endmodule : tb_top
